/* File: src/gwr_gpio.sv */
// gpio ports a..d with wake-up, drive levels and serial pin remapping
// assumes an apb master on ref_clk and pins asynchronous to ref_clk
// Functional notes
// - falling edge on enabled port a pin during sleep wakes device
// - eight port a wake enables, one per pin, cleared at reset
// - direction bit one makes pin input, zero makes cmos output
// - data and direction registers reset to all ones, pins start as inputs
// - reading an input pin returns the live pin level
// - reading an output pin returns the data latch, not the pin
// - pin turned output without a data write drives high
// - bit set or clear is software read-modify-write of the whole byte
// - each drive field is two bits, 00 minimum to 11 maximum
// - first drive register holds b high, b low, a high, a low, reset level 1
// - second drive register holds d, c high, c low; bits 7..6 read zero
// - serial out goes to pc3, pa1 or pc2; code 10 undefined
// - serial in / i2c data on pc4 or pa3
// - serial clock / i2c clock on pc5 or pb6
// - slave select on pc6 or pb5
// - uart transmit on pd2 or pb3
// - uart receive on pd1 or pb4
// - remap bit 7 enables receive path; remap register resets to zero
// - shared function output outranks plain port output on a pin
// - pull-high per pin, effective only as input, cleared at reset
// - inputs are not latched, output data held until rewritten
`timescale 1ns/1ps
`include "gwr_regs.svh"
module gwr_gpio
  import gwr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe,
  output logic      [7:0]  pa_pull,
  input  wire logic [6:0]  pb_in,
  output logic      [6:0]  pb_out,
  output logic      [6:0]  pb_oe,
  output logic      [6:0]  pb_pull,
  input  wire logic [6:0]  pc_in,
  output logic      [6:0]  pc_out,
  output logic      [6:0]  pc_oe,
  output logic      [6:0]  pc_pull,
  input  wire logic [3:0]  pd_in,
  output logic      [3:0]  pd_out,
  output logic      [3:0]  pd_oe,
  output logic      [3:0]  pd_pull,
  output logic      [3:0]  porta_drive_level,
  output logic      [3:0]  portb_drive_level,
  output logic      [3:0]  portc_drive_level,
  output logic      [1:0]  portd_drive_level,
  input  wire logic        sleep_mode,
  output logic             wake,
  input  wire logic        spi_sdo,
  input  wire logic        spi_sdo_oe,
  output logic             spi_sdi,
  input  wire logic        sda_out,
  input  wire logic        sda_oe,
  input  wire logic        sck_out,
  input  wire logic        sck_oe,
  output logic             sck_in,
  output logic             scs_in,
  input  wire logic        uart_tx,
  input  wire logic        uart_tx_oe,
  output logic             uart_rx
);

  logic [31:0] data;
  logic [31:0] dir;
  logic [31:0] pull;
  logic [7:0]  wake_en;
  logic [7:0]  wake_flag;
  logic [7:0]  drv_ab;
  logic [5:0]  drv_cd;
  logic [7:0]  remap;
  logic [31:0] pin_raw;
  logic [31:0] s1;
  logic [31:0] s2;
  logic [31:0] s3;
  logic [31:0] fo;
  logic [31:0] foe;
  logic [31:0] pin_o;
  logic [31:0] pin_oe;
  logic [31:0] pin_pu;
  logic [31:0] rd_val;
  logic        hit;
  logic        err;
  logic        acc;
  logic        wr;
  logic [7:0]  wake_evt;
  gwr_sdo_sel_t sdo_sel;

  // pin synchroniser
  assign pin_raw = {4'h0, pd_in, 1'b0, pc_in, 1'b0, pb_in, pa_in};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= 32'h0;
      s2 <= 32'h0;
      s3 <= 32'h0;
    end else begin
      s1 <= pin_raw;
      s2 <= s1 & `GWR_PIN_MASK;
      s3 <= s2;
    end
  end

  // apb access
  assign acc     = psel && penable;
  assign wr      = acc && pwrite && hit;
  assign pready  = acc;
  assign pslverr = acc && err;

  always_comb begin
    rd_val = 32'h0;
    hit    = 1'b1;
    unique case (paddr)
      `GWR_OFS_DRV_AB:    rd_val = {24'h0, drv_ab};
      `GWR_OFS_DRV_CD:    rd_val = {26'h0, drv_cd};
      `GWR_OFS_REMAP:     rd_val = {24'h0, remap};
      `GWR_OFS_WAKE_FLAG: rd_val = {24'h0, wake_flag};
      `GWR_OFS_WAKE_EN:   rd_val = {24'h0, wake_en};
      default: begin
        hit = 1'b0;
        for (int p = 0; p < 4; p++) begin
          if (paddr == 8'(p * 16) + `GWR_OFS_DATA) begin
            // input reads live pin, output reads latch
            rd_val = {24'h0, (dir[p*8 +: 8] & s2[p*8 +: 8])
                           | (~dir[p*8 +: 8] & data[p*8 +: 8])};
            hit = 1'b1;
          end
          if (paddr == 8'(p * 16) + `GWR_OFS_DIR) begin
            rd_val = {24'h0, dir[p*8 +: 8]};
            hit = 1'b1;
          end
          if (paddr == 8'(p * 16) + `GWR_OFS_PULL) begin
            rd_val = {24'h0, pull[p*8 +: 8]};
            hit = 1'b1;
          end
        end
      end
    endcase
  end

  // read data and error captured in the setup cycle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
      err    <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_val;
      err    <= !hit;
    end
  end

  // per-port data, direction and pull registers
  for (genvar p = 0; p < 4; p++) begin : g_port
    localparam logic [7:0] BASE = 8'(p * 16);
    localparam logic [7:0] MSK  = 8'(`GWR_PIN_MASK >> (p * 8));
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        data[p*8 +: 8] <= 8'(`GWR_DATA_RST >> (p * 8));
        dir[p*8 +: 8]  <= 8'(`GWR_DIR_RST >> (p * 8));
        pull[p*8 +: 8] <= 8'h00;
      end else if (wr) begin
        if (paddr == BASE + `GWR_OFS_DATA)
          data[p*8 +: 8] <= pwdata[7:0] & MSK;
        if (paddr == BASE + `GWR_OFS_DIR)
          dir[p*8 +: 8] <= pwdata[7:0] & MSK;
        if (paddr == BASE + `GWR_OFS_PULL)
          pull[p*8 +: 8] <= pwdata[7:0] & MSK;
      end
    end
  end

  // drive levels, remap and wake enable
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      drv_ab  <= `GWR_DRV_AB_RST;
      drv_cd  <= `GWR_DRV_CD_RST;
      remap   <= 8'h00;
      wake_en <= 8'h00;
    end else if (wr) begin
      if (paddr == `GWR_OFS_DRV_AB)
        drv_ab <= pwdata[7:0];
      if (paddr == `GWR_OFS_DRV_CD)
        drv_cd <= pwdata[5:0];
      if (paddr == `GWR_OFS_REMAP)
        remap <= pwdata[7:0];
      if (paddr == `GWR_OFS_WAKE_EN)
        wake_en <= pwdata[7:0];
    end
  end

  assign porta_drive_level = drv_ab[3:0];
  assign portb_drive_level = drv_ab[7:4];
  assign portc_drive_level = drv_cd[3:0];
  assign portd_drive_level = drv_cd[5:4];

  // wake detection, sticky flags cleared by writing one
  assign wake_evt = s3[7:0] & ~s2[7:0] & wake_en & {8{sleep_mode}};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wake      <= 1'b0;
      wake_flag <= 8'h00;
    end else begin
      wake <= |wake_evt;
      if (wr && paddr == `GWR_OFS_WAKE_FLAG)
        wake_flag <= (wake_flag & ~pwdata[7:0]) | wake_evt;
      else
        wake_flag <= wake_flag | wake_evt;
    end
  end

  // shared function outputs
  assign sdo_sel = gwr_sdo_sel_t'(remap[`GWR_REMAP_SDO_HI:`GWR_REMAP_SDO_LO]);
  always_comb begin
    fo  = 32'h0;
    foe = 32'h0;
    unique case (sdo_sel)
      GWR_SDO_PC3: begin
        fo[`GWR_PIN_PC3]  = spi_sdo;
        foe[`GWR_PIN_PC3] = spi_sdo_oe;
      end
      GWR_SDO_PA1: begin
        fo[`GWR_PIN_PA1]  = spi_sdo;
        foe[`GWR_PIN_PA1] = spi_sdo_oe;
      end
      GWR_SDO_PC2: begin
        fo[`GWR_PIN_PC2]  = spi_sdo;
        foe[`GWR_PIN_PC2] = spi_sdo_oe;
      end
      GWR_SDO_UNDEF: fo = 32'h0;
    endcase
    if (remap[`GWR_REMAP_SDI]) begin
      fo[`GWR_PIN_PA3]  = sda_out;
      foe[`GWR_PIN_PA3] = sda_oe;
    end else begin
      fo[`GWR_PIN_PC4]  = sda_out;
      foe[`GWR_PIN_PC4] = sda_oe;
    end
    if (remap[`GWR_REMAP_SCK]) begin
      fo[`GWR_PIN_PB6]  = sck_out;
      foe[`GWR_PIN_PB6] = sck_oe;
    end else begin
      fo[`GWR_PIN_PC5]  = sck_out;
      foe[`GWR_PIN_PC5] = sck_oe;
    end
    if (remap[`GWR_REMAP_TX]) begin
      fo[`GWR_PIN_PB3]  = uart_tx;
      foe[`GWR_PIN_PB3] = uart_tx_oe;
    end else begin
      fo[`GWR_PIN_PD2]  = uart_tx;
      foe[`GWR_PIN_PD2] = uart_tx_oe;
    end
  end

  // pin drive: shared function wins over port latch
  assign pin_oe = (foe | ~dir) & `GWR_PIN_MASK;
  assign pin_o  = (foe & fo) | (~foe & data);
  assign pin_pu = pull & dir & ~foe;
  assign pa_out  = pin_o[7:0];
  assign pa_oe   = pin_oe[7:0];
  assign pa_pull = pin_pu[7:0];
  assign pb_out  = pin_o[14:8];
  assign pb_oe   = pin_oe[14:8];
  assign pb_pull = pin_pu[14:8];
  assign pc_out  = pin_o[22:16];
  assign pc_oe   = pin_oe[22:16];
  assign pc_pull = pin_pu[22:16];
  assign pd_out  = pin_o[27:24];
  assign pd_oe   = pin_oe[27:24];
  assign pd_pull = pin_pu[27:24];

  // shared function inputs
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      spi_sdi <= 1'b1;
      sck_in  <= 1'b1;
      scs_in  <= 1'b1;
      uart_rx <= 1'b1;
    end else begin
      spi_sdi <= remap[`GWR_REMAP_SDI] ? s2[`GWR_PIN_PA3]
                                       : s2[`GWR_PIN_PC4];
      sck_in  <= remap[`GWR_REMAP_SCK] ? s2[`GWR_PIN_PB6]
                                       : s2[`GWR_PIN_PC5];
      scs_in  <= remap[`GWR_REMAP_SCS] ? s2[`GWR_PIN_PB5]
                                       : s2[`GWR_PIN_PC6];
      if (!remap[`GWR_REMAP_RX_EN])
        uart_rx <= 1'b1;
      else
        uart_rx <= remap[`GWR_REMAP_RX] ? s2[`GWR_PIN_PB4]
                                        : s2[`GWR_PIN_PD1];
    end
  end

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence s_rd_a_setup;
    psel && !penable && !pwrite && paddr == `GWR_OFS_DATA;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence

  property p_wake_fall;
    (sleep_mode && |(wake_en & s3[7:0] & ~s2[7:0])) |=> wake;
  endproperty
  a_wake_fall: assert property (p_wake_fall)
    else $error("enabled port a falling edge did not wake");
  property p_wake_quiet;
    !sleep_mode |=> !wake;
  endproperty
  a_wake_quiet: assert property (p_wake_quiet)
    else $error("wake raised while awake");
  property p_dir_oe;
    (foe[7:0] == 8'h00) |-> (pa_oe == ~dir[7:0]);
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("port a enable does not follow direction");
  property p_rd_input;
    (s_rd_a_setup and dir[7:0] == 8'hFF) ##1 s_access
      |-> prdata[7:0] == $past(s2[7:0]);
  endproperty
  a_rd_input: assert property (p_rd_input)
    else $error("input read did not return pin level");
  property p_rd_output;
    (s_rd_a_setup and dir[7:0] == 8'h00) ##1 s_access
      |-> prdata[7:0] == $past(data[7:0]);
  endproperty
  a_rd_output: assert property (p_rd_output)
    else $error("output read did not return latch");
  property p_cd_upper_zero;
    (psel && !penable && !pwrite && paddr == `GWR_OFS_DRV_CD) ##1 s_access
      |-> prdata[31:6] == 26'h0;
  endproperty
  a_cd_upper_zero: assert property (p_cd_upper_zero)
    else $error("unimplemented drive bits read nonzero");
  property p_rx_off;
    !remap[`GWR_REMAP_RX_EN] |=> uart_rx;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receive path not idle while disabled");
  property p_latch_write;
    (s_access and (pwrite && paddr == `GWR_OFS_DATA))
      |=> data[7:0] == $past(pwdata[7:0]);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("port a latch did not take write");
  property p_tx_remap;
    (remap[`GWR_REMAP_TX] && uart_tx_oe)
      |-> pb_oe[3] && pb_out[3] == uart_tx;
  endproperty
  a_tx_remap: assert property (p_tx_remap)
    else $error("transmit not driven on remapped pin");

endmodule : gwr_gpio

/* File: pkg/gwr_regs.svh */
// register offsets, field positions and reset values of the gpio block
// assumes a byte-addressed apb window of 256 bytes, one word per register
`ifndef GWR_REGS_SVH
`define GWR_REGS_SVH
`define GWR_PORT_STRIDE   8'h10
`define GWR_OFS_DATA      8'h00
`define GWR_OFS_DIR       8'h04
`define GWR_OFS_PULL      8'h08
`define GWR_OFS_WAKE_EN   8'h0C
`define GWR_OFS_DRV_AB    8'h40
`define GWR_OFS_DRV_CD    8'h44
`define GWR_OFS_REMAP     8'h48
`define GWR_OFS_WAKE_FLAG 8'h4C
`define GWR_PIN_MASK      32'h0F7F7FFF
`define GWR_DATA_RST      32'h0F7F7FFF
`define GWR_DIR_RST       32'h0F7F7FFF
`define GWR_DRV_AB_RST    8'h55
`define GWR_DRV_CD_RST    6'h15
`define GWR_REMAP_RX_EN   7
`define GWR_REMAP_SDO_HI  6
`define GWR_REMAP_SDO_LO  5
`define GWR_REMAP_SDI     4
`define GWR_REMAP_SCK     3
`define GWR_REMAP_SCS     2
`define GWR_REMAP_TX      1
`define GWR_REMAP_RX      0
`define GWR_PIN_PA1       1
`define GWR_PIN_PA3       3
`define GWR_PIN_PB3       11
`define GWR_PIN_PB4       12
`define GWR_PIN_PB5       13
`define GWR_PIN_PB6       14
`define GWR_PIN_PC2       18
`define GWR_PIN_PC3       19
`define GWR_PIN_PC4       20
`define GWR_PIN_PC5       21
`define GWR_PIN_PC6       22
`define GWR_PIN_PD1       25
`define GWR_PIN_PD2       26
`endif

/* File: pkg/gwr_pkg.sv */
// types shared by the gpio block
// assumes gwr_regs.svh supplies the numeric constants
package gwr_pkg;
  typedef logic [1:0] gwr_level_t;
  typedef enum logic [1:0] {
    GWR_SDO_PC3   = 2'b00,
    GWR_SDO_PA1   = 2'b01,
    GWR_SDO_UNDEF = 2'b10,
    GWR_SDO_PC2   = 2'b11
  } gwr_sdo_sel_t;
endpackage : gwr_pkg

/* File: bench/gwr_pin_model.sv */
// pin-side model: switches, pull-high and floating lines on ports a..d
// assumes eight-bit lanes per port, port a in bits 7..0
`timescale 1ns/1ps
module gwr_pin_model (
  input  wire logic        ref_clk,
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] pin_pull,
  input  wire logic [31:0] sw_en,
  input  wire logic [31:0] sw_val,
  output logic      [31:0] pin_lvl
);
  logic [31:0] float_pat = 32'h0;
  // undriven line without pull wanders each cycle
  always @(posedge ref_clk) float_pat <= ~float_pat;
  // block output first, then switch, then pull-high
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & sw_en & sw_val)
    | (~pin_oe & ~sw_en & (pin_pull | float_pat));
endmodule : gwr_pin_model

/* File: bench/test_gwr_gpio.sv */
// testbench of the gpio block: apb register tests and pin scenarios
// assumes gwr_gpio and gwr_pin_model, zero-wait apb slave
`timescale 1ns/1ps
`include "gwr_regs.svh"
`define GWR_CHK(w, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", w, e, g); \
  end \
end
module test_gwr_gpio;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, wake, sleep_mode = 1'b0;
  logic [7:0]  pa_out, pa_oe, pa_pull;
  logic [6:0]  pb_out, pb_oe, pb_pull, pc_out, pc_oe, pc_pull;
  logic [3:0]  pd_out, pd_oe, pd_pull;
  logic [3:0]  porta_drive_level, portb_drive_level, portc_drive_level;
  logic [1:0]  portd_drive_level;
  logic        spi_sdo = 1'b0, spi_sdo_oe = 1'b0, sda_out = 1'b0;
  logic        sda_oe = 1'b0, sck_out = 1'b0, sck_oe = 1'b0;
  logic        uart_tx = 1'b0, uart_tx_oe = 1'b0;
  logic        spi_sdi, sck_in, scs_in, uart_rx;
  logic [31:0] sw_val = 32'h0A5A3CA5;
  logic [31:0] sw_en = 32'hFFFFFFFF;
  logic [31:0] lvl, all_out, all_oe, all_pull;
  int          n_errors = 0, compares = 0, cycles = 0, n_wake = 0;

  assign all_out = {4'h0, pd_out, 1'b0, pc_out, 1'b0, pb_out, pa_out};
  assign all_oe = {4'h0, pd_oe, 1'b0, pc_oe, 1'b0, pb_oe, pa_oe};
  assign all_pull = {4'h0, pd_pull, 1'b0, pc_pull, 1'b0, pb_pull, pa_pull};

  gwr_gpio gwr_gpio_inst (
    .ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pa_in(lvl[7:0]), .pa_out, .pa_oe, .pa_pull,
    .pb_in(lvl[14:8]), .pb_out, .pb_oe, .pb_pull, .pc_in(lvl[22:16]),
    .pc_out, .pc_oe, .pc_pull, .pd_in(lvl[27:24]), .pd_out, .pd_oe,
    .pd_pull, .porta_drive_level, .portb_drive_level, .portc_drive_level,
    .portd_drive_level, .sleep_mode, .wake, .spi_sdo, .spi_sdo_oe,
    .spi_sdi, .sda_out, .sda_oe, .sck_out, .sck_oe, .sck_in, .scs_in,
    .uart_tx, .uart_tx_oe, .uart_rx);
  gwr_pin_model gwr_pin_model_inst (
    .ref_clk, .pin_out(all_out), .pin_oe(all_oe), .pin_pull(all_pull),
    .sw_en, .sw_val, .pin_lvl(lvl));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task give_verdict;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge ref_clk) begin
    cycles++;
    if (wake === 1'b1) n_wake++;
    if (cycles == 20000) begin
      n_errors++;
      $display("timeout");
      give_verdict();
    end
  end

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [32:0] r);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k == 16) n_errors++;
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    xfer(1'b1, a, d, r);
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [32:0] e,
                    input string w);
    logic [32:0] r;
    xfer(1'b0, a, 32'h0, r);
    `GWR_CHK(w, e, r)
  endtask : rd

  task settle;
    repeat (4) @(posedge ref_clk);
  endtask : settle

  task done(input string t);
    $display("test %s done", t);
  endtask : done

  function automatic logic [31:0] fn_oe(input logic [7:0] r);
    fn_oe = 32'h0;
    if (r[6:5] == 2'b00) fn_oe[`GWR_PIN_PC3] = 1'b1;
    if (r[6:5] == 2'b01) fn_oe[`GWR_PIN_PA1] = 1'b1;
    if (r[6:5] == 2'b11) fn_oe[`GWR_PIN_PC2] = 1'b1;
    fn_oe[r[4] ? `GWR_PIN_PA3 : `GWR_PIN_PC4] = 1'b1;
    fn_oe[r[3] ? `GWR_PIN_PB6 : `GWR_PIN_PC5] = 1'b1;
    fn_oe[r[1] ? `GWR_PIN_PB3 : `GWR_PIN_PD2] = 1'b1;
  endfunction : fn_oe

  initial begin
    static logic [7:0] rt [4] = '{8'h80, 8'hBF, 8'h5F, 8'hE0};
    logic [31:0] fm, fo, im;
    logic [32:0] r;
    logic [7:0]  lm;
    logic [3:0]  fi;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    settle;
    for (int p = 0; p < 4; p++) begin
      lm = 8'(`GWR_PIN_MASK >> (8 * p));
      rd(8'(16 * p), {25'h0, 8'(sw_val >> (8 * p)) & lm}, "data");
      rd(8'(16 * p + 4), {25'h0, lm}, "dir");
      rd(8'(16 * p + 8), 33'h0, "pull");
    end
    rd(`GWR_OFS_WAKE_EN, 33'h0, "wake_en");
    rd(`GWR_OFS_DRV_AB, 33'h55, "drv_ab");
    rd(`GWR_OFS_DRV_CD, 33'h15, "drv_cd");
    rd(`GWR_OFS_REMAP, 33'h0, "remap");
    rd(8'h50, {1'b1, 32'h0}, "unmapped");
    done("reset");
    wr(`GWR_OFS_DIR, 32'hF0);
    wr(`GWR_OFS_PULL, 32'hFF);
    settle;
    `GWR_CHK("pa_oe", 8'h0F, pa_oe)
    `GWR_CHK("pa_out", 4'hF, pa_out[3:0])
    `GWR_CHK("pa_pull", 8'hF0, pa_pull)
    rd(`GWR_OFS_DATA, 33'hAF, "pa mixed");
    wr(`GWR_OFS_DATA, 32'h30);
    rd(`GWR_OFS_DATA, 33'hA0, "pa latch");
    xfer(1'b0, `GWR_OFS_DATA, 32'h0, r);
    wr(`GWR_OFS_DATA, r[31:0] | 32'h1);
    wr(`GWR_OFS_DIR, 32'h00);
    `GWR_CHK("pa rmw", 8'hA1, pa_out)
    `GWR_CHK("pa_pull out", 8'h00, pa_pull)
    wr(`GWR_OFS_DIR, 32'hFF);
    wr(`GWR_OFS_PULL, 32'h0);
    done("port a");
    wr(`GWR_OFS_DRV_AB, 32'hE4);
    `GWR_CHK("drv a", 4'b0100, porta_drive_level)
    `GWR_CHK("drv b", 4'b1110, portb_drive_level)
    wr(`GWR_OFS_DRV_CD, 32'hFF);
    rd(`GWR_OFS_DRV_CD, 33'h3F, "drv_cd");
    `GWR_CHK("drv cd", 6'h3F, {portd_drive_level, portc_drive_level})
    done("drive");
    wr(8'h24, 32'h73);
    wr(8'h20, 32'h0C);
    {spi_sdo_oe, sda_oe, sck_oe, uart_tx_oe} <= 4'hF;
    foreach (rt[i]) begin
      wr(`GWR_OFS_REMAP, {24'h0, rt[i]});
      fm = fn_oe(rt[i]);
      fo = fm | 32'h000C0000;
      im = 32'h0;
      im[rt[i][2] ? `GWR_PIN_PB5 : `GWR_PIN_PC6] = 1'b1;
      im[rt[i][0] ? `GWR_PIN_PB4 : `GWR_PIN_PD1] = 1'b1;
      sw_val <= ~im;
      settle;
      `GWR_CHK("fn oe", fo, all_oe)
      `GWR_CHK("fn out", fo & ~fm, all_out & fo)
      fi = {spi_sdi, sck_in, scs_in, uart_rx};
      `GWR_CHK("fn in", {3'b000, ~rt[i][7]}, fi)
    end
    {spi_sdo_oe, sda_oe, sck_oe, uart_tx_oe} <= 4'h0;
    wr(`GWR_OFS_REMAP, 32'h0);
    wr(8'h24, 32'h7F);
    done("remap");
    sw_val <= 32'hFFFFFFFF;
    wr(`GWR_OFS_WAKE_EN, 32'h04);
    rd(`GWR_OFS_WAKE_EN, 33'h04, "wake_en");
    sleep_mode <= 1'b1;
    settle;
    n_wake = 0;
    sw_val[3] <= 1'b0;
    settle;
    sw_val[2] <= 1'b0;
    settle;
    settle;
    `GWR_CHK("wakes", 1, n_wake)
    sw_val[2] <= 1'b1;
    sleep_mode <= 1'b0;
    settle;
    sw_val[2] <= 1'b0;
    settle;
    settle;
    `GWR_CHK("wakes awake", 1, n_wake)
    rd(`GWR_OFS_WAKE_FLAG, 33'h04, "wake flag");
    wr(`GWR_OFS_WAKE_FLAG, 32'h04);
    rd(`GWR_OFS_WAKE_FLAG, 33'h0, "wake flag clr");
    done("wake");
    give_verdict();
  end
endmodule : test_gwr_gpio
